// >>> shared/dfcw_map.vh
// Constants for the digital line filter, change detect and watchdog block
`ifndef DFCW_MAP_VH
`define DFCW_MAP_VH
// ==========================================================
// Geometry
`define DFCW_PORTS        12
`define DFCW_LINES        96
// ==========================================================
// Timing
`define DFCW_CLK_NS       40
`define DFCW_TICK_NS      100
`define DFCW_FILT_MIN_NS  400
`define DFCW_FILT_MAX_MS  200
`define DFCW_PWRUP_MS     400
// Filter interval register counts 100 ns ticks; 4 .. 2,000,000
`define DFCW_FILT_MIN_T   32'h0000_0004
`define DFCW_FILT_MAX_T   32'h001E_8480
// ==========================================================
// Power-up state codes per line
`define DFCW_PU_HIZ       2'h0
`define DFCW_PU_HIGH      2'h1
`define DFCW_PU_LOW       2'h2
`endif

// >>> rtl/dfcw_top.v
// Digital line bank: glitch filter, change detection, power-up states, output watchdog
//
// Contract
// - Twelve ports of eight lines, each line usable as bidirectional data.
// - Reject pulses under half the interval, pass pulses over the full interval.
// - Filter enabled per line; one shared interval from 400 ns to 200 ms.
// - Filtered inputs sampled every 100 ns sample tick.
// - Counter makes filter clock with period half the programmed interval.
// - New level accepted only when steady over two consecutive filter clock edges.
// - Rising and falling treated alike; passing may take two filter periods.
// - Output drivers stay disabled at power-up until power-up states apply.
// - Each line has a stored power-up state: hi-Z input, high, or low.
// - Power-up states take effect within 400 ms of power.
// - Change detection per line with separate rising and falling enables.
// - Any enabled edge on any enabled line raises change interrupt.
// - Change event does not say which line or which edge.
// - Overflow flag set when another edge arrives before previous event is handled.
// - Change-detect lines do not report state until the interrupt occurs.
// - Armed watchdog needs a reset command each timeout, else outputs go safe.
// - After expiry safe states hold until disarm plus new write, or reset.
// - Expiry indication stays asserted until watchdog is disarmed.
// - After expiry all host writes are discarded until disarm.
// - Tri-stated lines stay high impedance on expiry.
// - Watchdog timeout in 100 ns units with a 32-bit counter.
`timescale 1ns/1ps
`default_nettype none
`include "dfcw_map.vh"

module dfcw_top #(
  parameter PWRUP_CYCLES = `DFCW_PWRUP_MS * 1000000 / `DFCW_CLK_NS
) (
  input  wire        MCLK,
  input  wire        RST_B,
  input  wire [95:0] LINE_IN,
  output reg  [95:0] LINE_OUT,
  output reg  [95:0] LINE_OE,
  input  wire [95:0] PWRUP_DIR,
  input  wire [95:0] PWRUP_VAL,
  input  wire [95:0] OUT_DIR,
  input  wire [95:0] OUT_VAL,
  input  wire        OUT_WR,
  input  wire [95:0] FILT_EN,
  input  wire [31:0] FILT_TICKS,
  input  wire [95:0] RISE_EN,
  input  wire [95:0] FALL_EN,
  input  wire        CHG_ACK,
  input  wire        WDOG_ARM,
  input  wire        WDOG_DISARM,
  input  wire        WDOG_KICK,
  input  wire [31:0] WDOG_TIMEOUT,
  input  wire [95:0] SAFE_VAL,
  output reg  [95:0] LINE_STATE,
  output reg         CHG_IRQ,
  output reg         CHG_OVF,
  output reg         WDOG_EXPIRED,
  output reg         WDOG_ARMED,
  output reg         PWRUP_DONE
);

  localparam [7:0] TICK_DIV = `DFCW_TICK_NS / `DFCW_CLK_NS;
  localparam [1:0] ST_PWR  = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  // ==========================================================
  // Shared decoders
  // Per-bit select: take a where mask is set, else b
  function [95:0] pick;
    input [95:0] a;
    input [95:0] b;
    input [95:0] mask;
    begin
      pick = (a & mask) | (b & ~mask);
    end
  endfunction

  // One edge kind: level now set, level before clear, enabled
  function [95:0] edge_hit;
    input [95:0] now_lvl;
    input [95:0] old_lvl;
    input [95:0] en;
    begin
      edge_hit = now_lvl & ~old_lvl & en;
    end
  endfunction

  // Out-of-range intervals are pinned to the nearest legal end
  function [31:0] clamp_ticks;
    input [31:0] req;
    begin
      if (req < `DFCW_FILT_MIN_T)
        clamp_ticks = `DFCW_FILT_MIN_T;
      else if (req > `DFCW_FILT_MAX_T)
        clamp_ticks = `DFCW_FILT_MAX_T;
      else
        clamp_ticks = req;
    end
  endfunction

  // ==========================================================
  // Input synchroniser
  reg  [95:0] sync_a;
  reg  [95:0] sync_b;

  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      sync_a <= 96'h0;
      sync_b <= 96'h0;
    end
    else
    begin
      sync_a <= LINE_IN;
      sync_b <= sync_a;
    end
  end

  // ==========================================================
  // 100 ns sample tick; 40 ns clock gives a 2.5 cycle tick, so
  // alternate 3 and 2 cycles to keep the average exact.
  reg  [7:0]  tick_cnt;
  reg         tick_phase;
  reg         tick;

  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      tick_cnt   <= 8'h0;
      tick_phase <= 1'b0;
      tick       <= 1'b0;
    end
    else if (tick_cnt == (tick_phase ? TICK_DIV - 8'h1 : TICK_DIV))
    begin
      tick_cnt   <= 8'h0;
      tick_phase <= ~tick_phase;
      tick       <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 8'h1;
      tick     <= 1'b0;
    end
  end

  // ==========================================================
  // Filter clock: half the interval, counted in sample ticks
  reg  [31:0] filt_cnt;
  reg         filt_edge;
  wire [31:0] filt_clamp = clamp_ticks(FILT_TICKS);
  wire [31:0] filt_half  = {1'b0, filt_clamp[31:1]};

  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      filt_cnt  <= 32'h0;
      filt_edge <= 1'b0;
    end
    else if (tick)
    begin
      if (filt_cnt + 32'h1 >= filt_half)
      begin
        filt_cnt  <= 32'h0;
        filt_edge <= 1'b1;
      end
      else
      begin
        filt_cnt  <= filt_cnt + 32'h1;
        filt_edge <= 1'b0;
      end
    end
    else
      filt_edge <= 1'b0;
  end

  // ==========================================================
  // Per-line filter, change detection and read gating
  // Pulses between half and full interval may go either way,
  // depending on where they fall against the filter clock.
  reg  [95:0] sampled;
  reg  [95:0] stable;
  reg  [95:0] cand;
  reg  [95:0] filtered;
  reg  [95:0] filt_prev;
  wire [95:0] clean = pick(filtered, sampled, FILT_EN);
  wire [95:0] rise  = edge_hit(clean, filt_prev, RISE_EN);
  wire [95:0] fall  = edge_hit(filt_prev, clean, FALL_EN);
  wire        any_edge = |(rise | fall);
  wire [95:0] watched  = RISE_EN | FALL_EN;

  genvar g;
  generate
    for (g = 0; g < `DFCW_LINES; g = g + 1)
    begin : g_line
      always @(posedge MCLK)
      begin
        if (!RST_B)
        begin
          sampled[g]  <= 1'b0;
          cand[g]     <= 1'b0;
          stable[g]   <= 1'b0;
          filtered[g] <= 1'b0;
        end
        else
        begin
          if (tick)
            sampled[g] <= sync_b[g];
          // Any sample that differs from the candidate spoils its run
          if (tick && sampled[g] != cand[g])
          begin
            cand[g]   <= sampled[g];
            stable[g] <= 1'b0;
          end
          else if (filt_edge)
          begin
            if (stable[g])
              filtered[g] <= cand[g];
            stable[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      filt_prev  <= 96'h0;
      CHG_IRQ    <= 1'b0;
      CHG_OVF    <= 1'b0;
      LINE_STATE <= 96'h0;
    end
    else
    begin
      filt_prev <= clean;
      // Set wins over the acknowledge in the same cycle
      CHG_IRQ   <= any_edge | (CHG_IRQ & ~CHG_ACK);
      CHG_OVF   <= (any_edge & CHG_IRQ) | (CHG_OVF & ~CHG_ACK);
      // Watched lines refresh only on an event; others follow live
      LINE_STATE <= any_edge ? clean : pick(LINE_STATE, clean, watched);
    end
  end

  // ==========================================================
  // Power-up and output control with watchdog
  reg  [1:0]  state;
  reg  [31:0] pwr_cnt;
  reg  [31:0] wd_cnt;
  reg  [95:0] oe_q;
  reg  [95:0] out_q;

  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      state        <= ST_PWR;
      pwr_cnt      <= 32'h0;
      wd_cnt       <= 32'h0;
      oe_q         <= 96'h0;
      out_q        <= 96'h0;
      WDOG_EXPIRED <= 1'b0;
      WDOG_ARMED   <= 1'b0;
      PWRUP_DONE   <= 1'b0;
    end
    else
    begin
      case (state)
        ST_PWR:
        begin
          // Drivers stay off for a short settle well inside the limit
          if (pwr_cnt >= PWRUP_CYCLES / 1000)
          begin
            oe_q       <= PWRUP_DIR;
            out_q      <= PWRUP_VAL;
            PWRUP_DONE <= 1'b1;
            state      <= ST_RUN;
          end
          else
            pwr_cnt <= pwr_cnt + 32'h1;
        end
        ST_RUN:
        begin
          if (WDOG_EXPIRED)
          begin
            // Host writes, kicks and re-arms are dropped here
            if (WDOG_DISARM)
            begin
              WDOG_EXPIRED <= 1'b0;
              WDOG_ARMED   <= 1'b0;
            end
          end
          else
          begin
            if (OUT_WR)
            begin
              oe_q  <= OUT_DIR;
              out_q <= OUT_VAL;
            end
            if (WDOG_DISARM)
              WDOG_ARMED <= 1'b0;
            else if (WDOG_ARM && !WDOG_ARMED)
            begin
              WDOG_ARMED <= 1'b1;
              wd_cnt     <= WDOG_TIMEOUT;
            end
            else if (WDOG_ARMED)
            begin
              if (WDOG_KICK)
                wd_cnt <= WDOG_TIMEOUT;
              else if (tick)
              begin
                // Timeout of 0 or 1 trips on the first tick
                if (wd_cnt <= 32'h1)
                begin
                  WDOG_EXPIRED <= 1'b1;
                  // Tri-stated lines stay released
                  out_q <= pick(SAFE_VAL, out_q, oe_q);
                  wd_cnt <= 32'h0;
                end
                else
                  wd_cnt <= wd_cnt - 32'h1;
              end
            end
          end
        end
        default:
          state <= ST_PWR;
      endcase
    end
  end

  // ==========================================================
  // Output stage: pins come straight from these flops
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      LINE_OE  <= 96'h0;
      LINE_OUT <= 96'h0;
    end
    else
    begin
      LINE_OE  <= oe_q;
      LINE_OUT <= out_q;
    end
  end

endmodule
`default_nettype wire

// >>> sim/dfcw_props.sv
// Port checker for the line bank
`timescale 1ns/1ps
`default_nettype none
module dfcw_props (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic [95:0] LINE_OUT,
  input wire logic [95:0] LINE_OE,
  input wire logic [95:0] PWRUP_DIR,
  input wire logic        CHG_ACK,
  input wire logic        WDOG_DISARM,
  input wire logic [95:0] SAFE_VAL,
  input wire logic        CHG_IRQ,
  input wire logic        CHG_OVF,
  input wire logic        WDOG_EXPIRED,
  input wire logic        WDOG_ARMED,
  input wire logic        PWRUP_DONE
);
  // =======
  // Checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  wire held = WDOG_EXPIRED && !WDOG_DISARM;
  property p_oe_off; !PWRUP_DONE |-> LINE_OE == 96'h0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("early drive");
  property p_pwr; $rose(PWRUP_DONE) |=> LINE_OE == PWRUP_DIR; endproperty
  a_pwr: assert property (p_pwr) else $error("bad power-up dir");
  property p_safe; $rose(WDOG_EXPIRED) |=> ((LINE_OUT ^ SAFE_VAL) & LINE_OE) == 96'h0; endproperty
  a_safe: assert property (p_safe) else $error("no safe level");
  property p_frz; held |=> $stable(LINE_OE); endproperty
  a_frz: assert property (p_frz) else $error("enable moved");
  property p_exp; held |=> WDOG_EXPIRED; endproperty
  a_exp: assert property (p_exp) else $error("expiry dropped");
  property p_irq; CHG_IRQ && !CHG_ACK |=> CHG_IRQ; endproperty
  a_irq: assert property (p_irq) else $error("event lost");
  property p_ovf; $rose(CHG_OVF) |-> $past(CHG_IRQ); endproperty
  a_ovf: assert property (p_ovf) else $error("stray overflow");
  property p_ovf_hold; CHG_OVF && !CHG_ACK |=> CHG_OVF; endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
  property p_exp_arm; WDOG_EXPIRED |-> WDOG_ARMED; endproperty
  a_exp_arm: assert property (p_exp_arm) else $error("expired while unarmed");
  c_exp: cover property ($rose(WDOG_EXPIRED));
  c_irq: cover property ($rose(CHG_IRQ));
  c_ovf: cover property ($rose(CHG_OVF));
  c_pwr: cover property ($rose(PWRUP_DONE));
endmodule
bind dfcw_top dfcw_props dfcw_props_i (.*);
`default_nettype wire

// >>> sim/dfcw_field.sv
// Field side model of the 96 lines
`timescale 1ns/1ps
`default_nettype none
module dfcw_field (
  input  wire logic [95:0] line_out,
  input  wire logic [95:0] line_oe,
  input  wire logic [95:0] drive,
  output wire logic [95:0] line_in
);
  // Device wins where it drives
  assign line_in = (line_oe & line_out) | (~line_oe & drive);
endmodule
`default_nettype wire

// >>> sim/tb_dfcw_top.sv
// Self-checking bench for the line bank
`timescale 1ns/1ps
`default_nettype none
module tb_dfcw_top;
  // =======
  // Stimulus
  logic        MCLK = 1'b0, RST_B = 1'b0, OUT_WR = 1'b0, CHG_ACK = 1'b0;
  logic        WDOG_ARM = 1'b0, WDOG_DISARM = 1'b0, WDOG_KICK = 1'b0;
  logic [95:0] PWRUP_DIR = 96'hF, PWRUP_VAL = 96'h5, OUT_DIR = 96'h0, OUT_VAL = 96'h0;
  logic [95:0] FILT_EN = 96'h1_0000, RISE_EN = 96'h300, FALL_EN = 96'h200;
  logic [95:0] SAFE_VAL = 96'h5A00_0000, fld = 96'h0;
  logic [31:0] FILT_TICKS = 32'h8, WDOG_TIMEOUT = 32'h14;
  wire  [95:0] LINE_IN, LINE_OUT, LINE_OE, LINE_STATE;
  wire         CHG_IRQ, CHG_OVF, WDOG_EXPIRED, WDOG_ARMED, PWRUP_DONE;
  int          fails = 0, check_count = 0, cyc = 0;
  // Short power-up count keeps the run brief
  dfcw_top #(.PWRUP_CYCLES(1000)) dfcw_top_i (.*);
  dfcw_field dfcw_field_i (.line_out(LINE_OUT), .line_oe(LINE_OE), .drive(fld),
    .line_in(LINE_IN));
  always #20 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic wr(input logic [95:0] d, input logic [95:0] v);
    OUT_DIR <= d;
    OUT_VAL <= v;
    OUT_WR <= 1'b1;
    tick(1);
    OUT_WR <= 1'b0;
    tick(3);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    tick(8);
    chk(LINE_OE, 96'h0);
    RST_B <= 1'b1;
    for (int i = 0; i < 100 && PWRUP_DONE !== 1'b1; i++) tick(1);
    chk(PWRUP_DONE, 1'b1);
    tick(2);
    chk(LINE_OE, PWRUP_DIR);
    chk(LINE_OUT & PWRUP_DIR, PWRUP_VAL & PWRUP_DIR);
    $display("power-up done");
    wr(96'hFF00_0000, 96'h0F00_0000);
    chk(LINE_OE, 96'hFF00_0000);
    tick(10);
    chk(LINE_STATE & 96'hFF00_0000, 96'h0F00_0000);
    $display("write done");
    // Glitch well under half the interval
    fld <= 96'h1_0000;
    tick(6);
    fld <= 96'h0;
    tick(60);
    chk(LINE_STATE & 96'h1_0000, 96'h0);
    fld <= 96'h3_0000;
    tick(8);
    chk(LINE_STATE & 96'h3_0000, 96'h2_0000);
    tick(52);
    chk(LINE_STATE & 96'h3_0000, 96'h3_0000);
    fld <= 96'h0;
    tick(60);
    chk(LINE_STATE & 96'h3_0000, 96'h0);
    $display("filter done");
    fld <= 96'h100;
    tick(20);
    chk(CHG_IRQ, 1'b1);
    chk(LINE_STATE & 96'h100, 96'h100);
    fld <= 96'h300;
    tick(20);
    chk(CHG_OVF, 1'b1);
    CHG_ACK <= 1'b1;
    tick(1);
    CHG_ACK <= 1'b0;
    fld <= 96'h200;
    tick(20);
    chk({CHG_IRQ, CHG_OVF}, 2'h0);
    chk(LINE_STATE & 96'h100, 96'h100);
    fld <= 96'h0;
    tick(20);
    chk(CHG_IRQ, 1'b1);
    $display("change done");
    WDOG_ARM <= 1'b1;
    tick(1);
    WDOG_ARM <= 1'b0;
    repeat (4)
    begin
      tick(30);
      WDOG_KICK <= 1'b1;
      tick(1);
      WDOG_KICK <= 1'b0;
    end
    chk(WDOG_EXPIRED, 1'b0);
    chk(WDOG_ARMED, 1'b1);
    tick(80);
    chk(WDOG_EXPIRED, 1'b1);
    chk(LINE_OE, 96'hFF00_0000);
    chk(LINE_OUT & 96'hFF00_0000, 96'h5A00_0000);
    wr(96'hF, 96'hF);
    chk(LINE_OE, 96'hFF00_0000);
    chk(WDOG_EXPIRED, 1'b1);
    WDOG_DISARM <= 1'b1;
    tick(1);
    WDOG_DISARM <= 1'b0;
    tick(2);
    chk(WDOG_EXPIRED, 1'b0);
    chk(WDOG_ARMED, 1'b0);
    chk(LINE_OUT & 96'hFF00_0000, 96'h5A00_0000);
    wr(96'hFF, 96'h3C);
    chk(LINE_OE, 96'hFF);
    $display("watchdog done");
    end_of_test();
  end
endmodule
`default_nettype wire
